// [design/homing_pkg.sv]
// Constants and types shared by the homing sequencer files.
// Assumes one 25 MHz system clock and an asynchronous active-high reset.
package homing_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_HZ          = 25000000;
  localparam int          TIMEOUT_MS      = 10000;
  localparam int          CYCLES_PER_MS   = CLK_HZ / 1000;
  localparam logic [31:0] TIMEOUT_CYCLES  = 32'(TIMEOUT_MS * CYCLES_PER_MS);

  // ****************************************
  // Method codes
  // ****************************************
  localparam logic [7:0]  METHOD_NEG_LIM  = 8'h01;
  localparam logic [7:0]  METHOD_POS_LIM  = 8'h02;
  localparam logic [7:0]  METHOD_HOME_P   = 8'h03;
  localparam logic [7:0]  METHOD_HOME_PL  = 8'h04;
  localparam logic [7:0]  METHOD_HOME_N   = 8'h05;
  localparam logic [7:0]  METHOD_HOME_NL  = 8'h06;
  localparam logic [7:0]  METHOD_HOME_PR  = 8'h07;
  localparam logic [7:0]  METHOD_HOME_PRR = 8'h08;

  // ****************************************
  // Input vector positions
  // ****************************************
  localparam int          SW_NEG_LIM      = 0;
  localparam int          SW_POS_LIM      = 1;
  localparam int          SW_HOME         = 2;
  localparam int          SW_INDEX        = 3;
  localparam int          SW_COUNT        = 4;

  localparam logic [1:0]  SEL_NEG_LIM     = 2'h0;
  localparam logic [1:0]  SEL_POS_LIM     = 2'h1;
  localparam logic [1:0]  SEL_HOME        = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RUN_A = 3'b001,
    ST_RUN_B = 3'b010,
    ST_FINAL = 3'b011,
    ST_DONE  = 3'b100,
    ST_FAIL  = 3'b101
  } seq_state_t;

  typedef struct packed {
    logic       ok;
    logic       a_en;
    logic       a_high;
    logic       a_neg;
    logic       a_rise;
    logic       b_neg;
    logic       b_rise;
    logic       f_neg;
    logic       lim_rev;
    logic [1:0] sel;
  } plan_t;

endpackage : homing_pkg

// [design/homing_sequencer.sv]
// Homing sequencer for one servo axis, methods 1 to 8.
// Assumes control and speed inputs are on clk_in; switches and index are pins.
//
// Behaviour
// - High speed input drives fast search, low speed input drives slow search.
// - Home is the first index pulse after the qualifying switch edge.
// - Method 1, limit clear: fast negative, rise, slow positive, fall, index.
// - Method 1, limit set: slow positive, fall, then stop at index.
// - Method 2, limit clear: fast positive, rise, slow negative, fall, index.
// - Method 2, limit set: slow negative, fall, then stop at index.
// - Method 3, home clear: fast positive, rise, slow negative, fall, index.
// - Methods 3, 5, 7 home set: slow negative, fall, then index.
// - Method 4, home clear: slow positive, rise, then stop at index.
// - Method 4, home set: fast negative, fall, slow negative, rise, index.
// - Method 5, home clear: fast negative, rise, then slow positive.
// - Method 6, home clear: slow negative, rise, then stop at index.
// - Method 6, home set: fast positive, fall, slow negative, rise, index.
// - Methods 7, 8, home clear: fast positive, rise, slow negative.
// - Methods 7, 8: positive limit in fast search reverses to fast negative.
// - Method 7: after home fall in slow negative, stop at index.
// - Method 8, home clear: after fall reverse slow positive, stop at index.
// - Method 8, home set: slow negative, fall, slow positive, rise, index.
// - Attained shows in homing mode with target reached after success.
// - Error on timeout or excess deviation; cleared when a new run starts.
module homing_sequencer #(
  parameter logic [31:0] TIMEOUT_CYCLES = homing_pkg::TIMEOUT_CYCLES,
  parameter int          SPEED_W        = 32
) (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic               start_in,
  input  wire logic [7:0]         method_in,
  input  wire logic [SPEED_W-1:0] high_speed_in,
  input  wire logic [SPEED_W-1:0] low_speed_in,
  input  wire logic               homing_mode_in,
  input  wire logic               target_reached_in,
  input  wire logic               deviation_excess_in,
  input  wire logic               negative_limit_input_in,
  input  wire logic               positive_limit_input_in,
  input  wire logic               home_switch_in,
  input  wire logic               index_pulse_in,
  output logic      [SPEED_W-1:0] speed_out,
  output logic                    dir_neg_out,
  output logic                    move_out,
  output logic                    busy_out,
  output logic                    home_flag_out,
  output logic                    attained_out,
  output logic                    error_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    homing_pkg::seq_state_t st;
    homing_pkg::plan_t      plan;
    logic [31:0]            timer;
    logic [SPEED_W-1:0]     speed;
    logic                   neg;
    logic                   move;
    logic                   busy;
    logic                   flag;
    logic                   attained;
    logic                   error;
    logic                   start_d;
  } seq_t;

  seq_t state_reg;
  seq_t state_next;

  logic [homing_pkg::SW_COUNT-1:0] pin_level;
  logic [homing_pkg::SW_COUNT-1:0] pin_rise;
  logic [homing_pkg::SW_COUNT-1:0] pin_fall;
  logic [homing_pkg::SW_COUNT-1:0] pin_raw;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  assign pin_raw = {index_pulse_in, home_switch_in,
                    positive_limit_input_in, negative_limit_input_in};

  input_sync #(
    .WIDTH     (homing_pkg::SW_COUNT)
  ) input_sync_inst (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (pin_raw),
    .level_out (pin_level),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic pick(
    input logic [homing_pkg::SW_COUNT-1:0] vec,
    input logic [1:0]                      sel
  );
    logic res;
    res = 1'b0;
    case (sel)
      homing_pkg::SEL_NEG_LIM: res = vec[homing_pkg::SW_NEG_LIM];
      homing_pkg::SEL_POS_LIM: res = vec[homing_pkg::SW_POS_LIM];
      homing_pkg::SEL_HOME:    res = vec[homing_pkg::SW_HOME];
      default:                 res = 1'b0;
    endcase
    return res;
  endfunction : pick

  function automatic logic edge_seen(
    input logic       want_rise,
    input logic [1:0] sel
  );
    logic res;
    res = want_rise ? pick(pin_rise, sel) : pick(pin_fall, sel);
    return res;
  endfunction : edge_seen

  // Segment plan per method and switch level at start
  function automatic homing_pkg::plan_t plan_for(
    input logic [7:0] method,
    input logic       act_neg,
    input logic       act_pos,
    input logic       act_home
  );
    homing_pkg::plan_t p;
    p     = '0;
    p.ok  = 1'b1;
    p.sel = homing_pkg::SEL_HOME;
    case (method)
      homing_pkg::METHOD_NEG_LIM:
      begin
        p.sel    = homing_pkg::SEL_NEG_LIM;
        p.a_en   = !act_neg;
        p.a_high = 1'b1;
        p.a_neg  = 1'b1;
        p.a_rise = 1'b1;
        p.b_neg  = 1'b0;
      end
      homing_pkg::METHOD_POS_LIM:
      begin
        p.sel    = homing_pkg::SEL_POS_LIM;
        p.a_en   = !act_pos;
        p.a_high = 1'b1;
        p.a_rise = 1'b1;
        p.b_neg  = 1'b1;
        p.f_neg  = 1'b1;
      end
      homing_pkg::METHOD_HOME_P, homing_pkg::METHOD_HOME_PR:
      begin
        p.a_en    = !act_home;
        p.a_high  = 1'b1;
        p.a_rise  = 1'b1;
        p.b_neg   = 1'b1;
        p.f_neg   = 1'b1;
        p.lim_rev = (method == homing_pkg::METHOD_HOME_PR);
      end
      homing_pkg::METHOD_HOME_PL:
      begin
        p.a_en   = act_home;
        p.a_high = 1'b1;
        p.a_neg  = 1'b1;
        p.b_neg  = act_home;
        p.b_rise = 1'b1;
        p.f_neg  = act_home;
      end
      homing_pkg::METHOD_HOME_N:
      begin
        p.a_en   = !act_home;
        p.a_high = 1'b1;
        p.a_neg  = 1'b1;
        p.a_rise = 1'b1;
        p.b_neg  = act_home;
        p.f_neg  = act_home;
      end
      homing_pkg::METHOD_HOME_NL:
      begin
        p.a_en   = act_home;
        p.a_high = 1'b1;
        p.b_neg  = 1'b1;
        p.b_rise = 1'b1;
        p.f_neg  = 1'b1;
      end
      homing_pkg::METHOD_HOME_PRR:
      begin
        p.a_en    = 1'b1;
        p.a_high  = !act_home;
        p.a_neg   = act_home;
        p.a_rise  = !act_home;
        p.b_neg   = !act_home;
        p.b_rise  = act_home;
        p.lim_rev = !act_home;
      end
      default:
      begin
        p.ok = 1'b0;
      end
    endcase
    return p;
  endfunction : plan_for

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    homing_pkg::plan_t p;
    logic              start_rise;
    logic              running;
    p          = '0;
    start_rise = start_in && !state_reg.start_d;
    running    = (state_reg.st == homing_pkg::ST_RUN_A) ||
                 (state_reg.st == homing_pkg::ST_RUN_B) ||
                 (state_reg.st == homing_pkg::ST_FINAL);
    state_next          = state_reg;
    state_next.start_d  = start_in;
    state_next.attained = homing_mode_in && target_reached_in &&
                          state_reg.flag && (state_reg.st == homing_pkg::ST_DONE);
    state_next.speed    = ((state_reg.st == homing_pkg::ST_RUN_A) && state_reg.plan.a_high)
                          ? high_speed_in : low_speed_in;
    case (state_reg.st)
      homing_pkg::ST_IDLE, homing_pkg::ST_DONE, homing_pkg::ST_FAIL:
      begin
        state_next.move = 1'b0;
        state_next.busy = 1'b0;
        if (start_rise)
        begin
          p = plan_for(method_in, pin_level[homing_pkg::SW_NEG_LIM],
                       pin_level[homing_pkg::SW_POS_LIM], pin_level[homing_pkg::SW_HOME]);
          state_next.plan     = p;
          state_next.timer    = '0;
          state_next.flag     = 1'b0;
          state_next.attained = 1'b0;
          state_next.error    = !p.ok;
          if (!p.ok)
          begin
            state_next.st = homing_pkg::ST_FAIL;
          end
          else if (p.a_en)
          begin
            state_next.st    = homing_pkg::ST_RUN_A;
            state_next.neg   = p.a_neg;
            state_next.busy  = 1'b1;
            state_next.move  = 1'b1;
            state_next.speed = p.a_high ? high_speed_in : low_speed_in;
          end
          else
          begin
            state_next.st    = homing_pkg::ST_RUN_B;
            state_next.neg   = p.b_neg;
            state_next.busy  = 1'b1;
            state_next.move  = 1'b1;
            state_next.speed = low_speed_in;
          end
        end
      end
      homing_pkg::ST_RUN_A:
      begin
        if (state_reg.plan.lim_rev && !state_reg.neg &&
            pin_rise[homing_pkg::SW_POS_LIM])
        begin
          state_next.neg = 1'b1;
        end
        if (edge_seen(state_reg.plan.a_rise, state_reg.plan.sel))
        begin
          state_next.st    = homing_pkg::ST_RUN_B;
          state_next.neg   = state_reg.plan.b_neg;
          state_next.speed = low_speed_in;
        end
      end
      homing_pkg::ST_RUN_B:
      begin
        if (edge_seen(state_reg.plan.b_rise, state_reg.plan.sel))
        begin
          state_next.st  = homing_pkg::ST_FINAL;
          state_next.neg = state_reg.plan.f_neg;
        end
      end
      homing_pkg::ST_FINAL:
      begin
        if (pin_rise[homing_pkg::SW_INDEX])
        begin
          state_next.st   = homing_pkg::ST_DONE;
          state_next.move = 1'b0;
          state_next.busy = 1'b0;
          state_next.flag = 1'b1;
        end
      end
      default:
      begin
        state_next.st = homing_pkg::ST_IDLE;
      end
    endcase
    if (running && state_next.st != homing_pkg::ST_DONE)
    begin
      state_next.move = start_in;
      if (start_in)
      begin
        state_next.timer = state_reg.timer + 32'h00000001;
      end
      if (deviation_excess_in || (state_reg.timer >= TIMEOUT_CYCLES))
      begin
        state_next.st    = homing_pkg::ST_FAIL;
        state_next.error = 1'b1;
        state_next.move  = 1'b0;
        state_next.busy  = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg    <= '0;
      state_reg.st <= homing_pkg::ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign speed_out     = state_reg.speed;
  assign dir_neg_out   = state_reg.neg;
  assign move_out      = state_reg.move;
  assign busy_out      = state_reg.busy;
  assign home_flag_out = state_reg.flag;
  assign attained_out  = state_reg.attained;
  assign error_out     = state_reg.error;

endmodule : homing_sequencer

// [design/input_sync.sv]
// Two-flop synchroniser with edge detection for a vector of pins.
// Assumes inputs are asynchronous to clk_in.
module input_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // ****************************************
  // Synchroniser and edge detect
  // ****************************************
  always_comb
  begin
    state_next      = state_reg;
    state_next.meta = async_in;
    state_next.sync = state_reg.meta;
    state_next.prev = state_reg.sync;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign level_out = state_reg.sync;
  assign rise_out  = state_reg.sync & ~state_reg.prev;
  assign fall_out  = ~state_reg.sync & state_reg.prev;

endmodule : input_sync

// [test/axis_model.sv]
// Behavioural axis carrying two limit switches, home switch and index mark.
// Assumes one position step per clock while motion is commanded.
module axis_model (
  input  wire logic        clk_in,
  input  wire logic        move_in,
  input  wire logic        dir_neg_in,
  input  wire logic        hold_in,
  input  wire logic        load_in,
  input  wire logic [15:0] load_pos_in,
  output logic             neg_lim_out,
  output logic             pos_lim_out,
  output logic             home_out,
  output logic             index_out,
  output logic      [15:0] pos_out,
  output logic      [15:0] last_index_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pos_reg = 16'h0096;
  logic [15:0] idx_reg = 16'hFFFF;

  // ****************************************
  // Motion
  // ****************************************
  always @(posedge clk_in)
  begin
    if (load_in)
      pos_reg <= load_pos_in;
    else if (move_in && !hold_in)
      pos_reg <= dir_neg_in ? pos_reg - 16'h0001 : pos_reg + 16'h0001;
    if (load_in)
      idx_reg <= 16'hFFFF;
    else if (index_out)
      idx_reg <= pos_reg;
  end

  // ****************************************
  // Switch map
  // ****************************************
  always_comb
  begin
    pos_out        = pos_reg;
    last_index_out = idx_reg;
    neg_lim_out    = pos_reg <= 16'h001E;
    pos_lim_out    = pos_reg >= 16'h0168;
    home_out       = (pos_reg >= 16'h00DC && pos_reg <= 16'h0104) ||
                     (pos_reg >= 16'h005A && pos_reg <= 16'h0068);
    index_out      = pos_reg[4:0] == 5'h10;
  end
endmodule : axis_model

// [test/homing_sequencer_sva.sv]
// Concurrent checks on the homing sequencer ports.
// Assumes binding into homing_sequencer; one clock, async high reset.
module homing_sequencer_sva #(
  parameter logic [31:0] TIMEOUT_CYCLES = 32'h000000C8,
  parameter int          SPEED_W        = 32
) (
  input wire logic               clk_in,
  input wire logic               rst_in,
  input wire logic               start_in,
  input wire logic [7:0]         method_in,
  input wire logic [SPEED_W-1:0] high_speed_in,
  input wire logic [SPEED_W-1:0] low_speed_in,
  input wire logic               homing_mode_in,
  input wire logic               target_reached_in,
  input wire logic               deviation_excess_in,
  input wire logic               negative_limit_input_in,
  input wire logic               positive_limit_input_in,
  input wire logic               home_switch_in,
  input wire logic               index_pulse_in,
  input wire logic [SPEED_W-1:0] speed_out,
  input wire logic               dir_neg_out,
  input wire logic               move_out,
  input wire logic               busy_out,
  input wire logic               home_flag_out,
  input wire logic               attained_out,
  input wire logic               error_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] run_cnt_reg;
  logic [31:0] run_cnt_next;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ****************************************
  // Run time counter
  // ****************************************
  always_comb
  begin
    run_cnt_next = busy_out ? run_cnt_reg + {31'h0, start_in} : 32'h0;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      run_cnt_reg <= 32'h0;
    else
      run_cnt_reg <= run_cnt_next;
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_speed_choice: assert property (move_out |->
    (speed_out == high_speed_in || speed_out == low_speed_in)) else $error("bad speed");
  chk_done_stops: assert property ($rose(home_flag_out) |->
    !move_out && !busy_out) else $error("moving after home");
  chk_start_answer: assert property ($rose(start_in) && !busy_out &&
    method_in inside {[8'h01:8'h08]} && !deviation_excess_in |=> busy_out && move_out)
    else $error("start not taken");
  chk_idle_quiet: assert property (!start_in && !busy_out |=> !busy_out)
    else $error("run without start");
  chk_pause_stop: assert property (busy_out && !start_in ##1 !start_in |-> !move_out)
    else $error("pause ignored");
  chk_move_busy: assert property (move_out |-> busy_out) else $error("move while idle");
  chk_attained_cause: assert property (attained_out |->
    $past(homing_mode_in && target_reached_in && home_flag_out)) else $error("attained early");
  chk_attained_set: assert property (home_flag_out && !busy_out && homing_mode_in &&
    target_reached_in && $stable(start_in) |=> attained_out) else $error("attained missing");
  chk_dev_error: assert property (busy_out && deviation_excess_in |=>
    error_out && !busy_out) else $error("deviation not flagged");
  chk_timeout_bound: assert property (run_cnt_reg <= TIMEOUT_CYCLES + 32'h3)
    else $error("timeout missed");
  chk_error_stop: assert property ($rose(error_out) |->
    !move_out && !busy_out && !home_flag_out) else $error("error while moving");
  chk_bad_method: assert property ($rose(start_in) && !busy_out &&
    (method_in == 8'h00 || method_in > 8'h08) |=> !move_out ##[0:1] error_out)
    else $error("bad method run");

  cover property ($rose(home_flag_out));
  cover property ($rose(error_out));
  cover property ($rose(attained_out));
  cover property (busy_out && !start_in);
endmodule : homing_sequencer_sva

bind homing_sequencer homing_sequencer_sva #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .SPEED_W(SPEED_W)
) homing_sequencer_sva_inst (
  .clk_in, .rst_in, .start_in, .method_in, .high_speed_in, .low_speed_in,
  .homing_mode_in, .target_reached_in, .deviation_excess_in, .negative_limit_input_in,
  .positive_limit_input_in, .home_switch_in, .index_pulse_in, .speed_out, .dir_neg_out,
  .move_out, .busy_out, .home_flag_out, .attained_out, .error_out
);

// [test/homing_sequencer_tb.sv]
// Self-checking bench for the homing sequencer.
// Assumes axis_model drives the switch and index pins.
module homing_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] TMO = 32'h00000258;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        start_in = 1'b0;
  logic [7:0]  method_in = 8'h01;
  logic [31:0] high_speed_in = 32'h00001388;
  logic [31:0] low_speed_in = 32'h00000064;
  logic        homing_mode_in = 1'b1;
  logic        target_reached_in = 1'b1;
  logic        deviation_excess_in = 1'b0;
  logic        hold_in = 1'b0;
  logic        load_in = 1'b1;
  logic [15:0] load_pos_in = 16'h0096;
  logic        negative_limit_input_in, positive_limit_input_in, home_switch_in;
  logic        index_pulse_in, dir_neg_out, move_out, busy_out;
  logic        home_flag_out, attained_out, error_out;
  logic [31:0] speed_out;
  logic [15:0] pos, last_idx;
  int          err_total = 0;
  int          cmp_count = 0;
  int          tick = 0;

  homing_sequencer #(.TIMEOUT_CYCLES(TMO)) homing_sequencer_inst (
    .clk_in, .rst_in, .start_in, .method_in, .high_speed_in, .low_speed_in,
    .homing_mode_in, .target_reached_in, .deviation_excess_in, .negative_limit_input_in,
    .positive_limit_input_in, .home_switch_in, .index_pulse_in, .speed_out, .dir_neg_out,
    .move_out, .busy_out, .home_flag_out, .attained_out, .error_out);

  axis_model axis_model_inst (
    .clk_in, .move_in(move_out), .dir_neg_in(dir_neg_out), .hold_in, .load_in,
    .load_pos_in, .neg_lim_out(negative_limit_input_in),
    .pos_lim_out(positive_limit_input_in), .home_out(home_switch_in),
    .index_out(index_pulse_in), .pos_out(pos), .last_index_out(last_idx));

  always #20 clk_in = ~clk_in;

  always @(posedge clk_in)
  begin
    tick = tick + 1;
    if (tick == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic place(input logic [15:0] p);
    @(posedge clk_in);
    load_in     <= 1'b1;
    load_pos_in <= p;
    @(posedge clk_in);
    load_in <= 1'b0;
    repeat (5) @(posedge clk_in);
  endtask : place

  task automatic kick(input logic [7:0] m, input logic [15:0] p);
    place(p);
    method_in <= m;
    start_in  <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
  endtask : kick

  task automatic run_case(input logic [7:0] m, input logic [15:0] p, input logic neg,
                          input logic fast, input logic [15:0] home, input bit pause);
    int          i;
    logic [15:0] at;
    kick(m, p);
    check(dir_neg_out, neg);
    check(speed_out, fast ? high_speed_in : low_speed_in);
    check(move_out, 1'b1);
    if (pause)
    begin
      repeat (20) @(posedge clk_in);
      start_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      #1;
      at = pos;
      repeat (5) @(posedge clk_in);
      #1;
      check(pos, at);
      check(busy_out, 1'b1);
      @(posedge clk_in);
      start_in <= 1'b1;
    end
    for (i = 0; i < 1000 && busy_out !== 1'b0; i++)
    begin
      @(posedge clk_in);
      #1;
    end
    repeat (2) @(posedge clk_in);
    #1;
    check(home_flag_out, 1'b1);
    check(error_out, 1'b0);
    check(last_idx, home);
    check(attained_out, homing_mode_in & target_reached_in);
    check(speed_out, low_speed_in);
    @(posedge clk_in);
    start_in <= 1'b0;
  endtask : run_case

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_limits();
    run_case(8'h01, 16'h0096, 1'b1, 1'b1, 16'h0030, 1'b0);
    run_case(8'h01, 16'h0014, 1'b0, 1'b0, 16'h0030, 1'b0);
    run_case(8'h02, 16'h012C, 1'b0, 1'b1, 16'h0150, 1'b0);
    run_case(8'h02, 16'h0172, 1'b1, 1'b0, 16'h0150, 1'b0);
    $display("t_limits done, mismatches %0d", err_total);
  endtask : t_limits

  task automatic t_home();
    run_case(8'h03, 16'h0096, 1'b0, 1'b1, 16'h00D0, 1'b0);
    run_case(8'h03, 16'h00EC, 1'b1, 1'b0, 16'h00D0, 1'b0);
    run_case(8'h05, 16'h00EC, 1'b1, 1'b0, 16'h00D0, 1'b0);
    run_case(8'h07, 16'h00EC, 1'b1, 1'b0, 16'h00D0, 1'b0);
    run_case(8'h04, 16'h0096, 1'b0, 1'b0, 16'h00F0, 1'b0);
    run_case(8'h04, 16'h00EC, 1'b1, 1'b1, 16'h0050, 1'b0);
    run_case(8'h05, 16'h012C, 1'b1, 1'b1, 16'h0110, 1'b0);
    run_case(8'h06, 16'h012C, 1'b1, 1'b0, 16'h00F0, 1'b0);
    run_case(8'h06, 16'h00EC, 1'b0, 1'b1, 16'h00F0, 1'b0);
    $display("t_home done, mismatches %0d", err_total);
  endtask : t_home

  task automatic t_ref();
    run_case(8'h07, 16'h0096, 1'b0, 1'b1, 16'h00D0, 1'b0);
    run_case(8'h07, 16'h0118, 1'b0, 1'b1, 16'h00D0, 1'b0);
    run_case(8'h08, 16'h0096, 1'b0, 1'b1, 16'h00F0, 1'b0);
    run_case(8'h08, 16'h0118, 1'b0, 1'b1, 16'h00F0, 1'b0);
    run_case(8'h08, 16'h00EC, 1'b1, 1'b0, 16'h00F0, 1'b0);
    $display("t_ref done, mismatches %0d", err_total);
  endtask : t_ref

  task automatic t_faults();
    int n;
    kick(8'h00, 16'h0096);
    check(error_out, 1'b1);
    check(move_out, 1'b0);
    @(posedge clk_in);
    start_in <= 1'b0;
    kick(8'h09, 16'h0096);
    check(move_out, 1'b0);
    @(posedge clk_in);
    start_in <= 1'b0;
    kick(8'h03, 16'h0096);
    repeat (20) @(posedge clk_in);
    deviation_excess_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    check({error_out, busy_out, move_out}, 3'h4);
    @(posedge clk_in);
    deviation_excess_in <= 1'b0;
    start_in            <= 1'b0;
    hold_in             <= 1'b1;
    kick(8'h03, 16'h0096);
    for (n = 0; n < 700 && error_out !== 1'b1; n++)
    begin
      @(posedge clk_in);
      #1;
    end
    check(32'(n > 590 && n < 605), 32'h1);
    @(posedge clk_in);
    hold_in  <= 1'b0;
    start_in <= 1'b0;
    $display("t_faults done, mismatches %0d", err_total);
  endtask : t_faults

  task automatic t_extra();
    run_case(8'h03, 16'h0096, 1'b0, 1'b1, 16'h00D0, 1'b1);
    homing_mode_in <= 1'b0;
    run_case(8'h01, 16'h0096, 1'b1, 1'b1, 16'h0030, 1'b0);
    homing_mode_in    <= 1'b1;
    target_reached_in <= 1'b0;
    run_case(8'h02, 16'h012C, 1'b0, 1'b1, 16'h0150, 1'b0);
    target_reached_in <= 1'b1;
    kick(8'h03, 16'h0096);
    @(posedge clk_in);
    rst_in   <= 1'b1;
    start_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    check({busy_out, move_out, home_flag_out, error_out}, 32'h0);
    @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    check({busy_out, move_out}, 32'h0);
    $display("t_extra done, mismatches %0d", err_total);
  endtask : t_extra

  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_in  <= 1'b0;
    load_in <= 1'b0;
    t_limits();
    t_home();
    t_ref();
    t_faults();
    t_extra();
    end_of_test();
  end
endmodule : homing_sequencer_tb
